// ===== verilog/ulw_pkg.sv
/*
  Shared types and constants for the serial routing and wait control block.
  Assumes a single 200 MHz clock and a synchronous active-low reset.
*/
package ulw_pkg;

  localparam int unsigned CLOCK_MHZ      = 200;
  localparam int unsigned CLOCK_PERIOD_PS = 5000;
  localparam int unsigned SYNC_STAGES    = 2;
  localparam int unsigned BAUD_DIV_RESET = 16;
  localparam logic        LINE_IDLE      = 1'h1;

  // configuration held in the control word
  typedef struct packed {
    logic wrapSelect;
    logic rxSourceSel;
    logic rxInvert;
    logic txInvert;
    logic stopInWait;
    logic xmitOn;
    logic rcvOn;
  } ulw_ctrl_type;

  localparam ulw_ctrl_type CTRL_RESET = '{
    wrapSelect:  1'h0,
    rxSourceSel: 1'h0,
    rxInvert:    1'h0,
    txInvert:    1'h0,
    stopInWait:  1'h0,
    xmitOn:      1'h0,
    rcvOn:       1'h0
  };

  // routing of the receiver input
  typedef enum logic [1:0] {
    ROUTE_PIN,
    ROUTE_WRAP,
    ROUTE_SINGLE
  } ulw_route_type;

  typedef struct packed {
    logic xmitActive;
    logic rcvActive;
    logic lowPower;
  } ulw_status_type;

  localparam ulw_status_type STATUS_RESET = '{
    xmitActive: 1'h0,
    rcvActive:  1'h0,
    lowPower:   1'h0
  };

endpackage

// ===== verilog/ulw_clk_div.sv
/*
  Serial clock divider: one-cycle enable pulse every DIV cycles.
  Assumes run is from logic on the same clock; holding run low freezes
  the count so the phase resumes where it stopped.
*/
`timescale 1ns/1ps
module ulw_clk_div
  import ulw_pkg::*;
#(
  parameter int unsigned DIV = BAUD_DIV_RESET
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic run,
  output logic      tick
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  // refused at elaboration: a zero divide has no last count
  if (DIV < 1) begin
    $error("ulw_clk_div: DIV must be at least 1");
  end

  logic [CW-1:0] count;
  wire           atLast = (count == LAST);
  wire [CW-1:0]  next_count = atLast ? '0 : count + CW'(1);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      count <= '0;
      tick  <= 1'h0;
    end else begin
      // frozen count: no pulses while stopped
      if (run) begin
        count <= next_count;
      end
      tick <= run && atLast;
    end
  end

endmodule

// ===== verilog/uart_loopback_wait_ctl.sv
/*
  Receive-path routing, polarity and wait-mode clock gating for a UART.
  Assumes the transmitter and receiver sit on the same clock, that the
  configuration ports are driven by same-clock control logic, and that
  the two pins come from outside and are synchronised here.
*/
// Summary of operation
// - with wrap select set, activity on the receive pin never reaches the receiver.
// - with wrap select set and source select clear, the transmit line feeds the receiver internally.
// - receive inversion is applied on its own, so looped data is right only when both inversions match.
// - in single-wire use the data read back from the transmit pin is inverted when receive inversion is set.
// - with stop-in-wait clear, transmit and receive run on during processor wait.
// - with stop-in-wait set during processor wait, serial clocks stop and the block idles in low power.
// - setting stop-in-wait leaves the stored transmit and receive enables as they were.
`timescale 1ns/1ps
module uart_loopback_wait_ctl
  import ulw_pkg::*;
#(
  parameter int unsigned BAUD_DIV = BAUD_DIV_RESET
) (
  input  wire logic           clock,
  input  wire logic           resetn,
  input  wire ulw_ctrl_type   ctrlOne,
  input  wire logic           cpuWait,
  input  wire logic           txData,
  input  wire logic           rxPin,
  input  wire logic           txPinIn,
  output logic                txPinOut,
  output logic                txPinOe,
  output logic                rxData,
  output logic                baudTick,
  output ulw_status_type      status
);

  if (BAUD_DIV < 1) begin
    $error("uart_loopback_wait_ctl: BAUD_DIV below 1");
  end

  // stored control word; only reloaded from the port, never by wait logic
  ulw_ctrl_type ctrl;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl <= CTRL_RESET;
    end else begin
      ctrl <= ctrlOne;
    end
  end

  // two-stage synchronisers for both pins
  logic rxPinMeta;
  logic rxPinSync;
  logic txPinMeta;
  logic txPinSync;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rxPinMeta <= LINE_IDLE;
      rxPinSync <= LINE_IDLE;
      txPinMeta <= LINE_IDLE;
      txPinSync <= LINE_IDLE;
    end else begin
      rxPinMeta <= rxPin;
      rxPinSync <= rxPinMeta;
      txPinMeta <= txPinIn;
      txPinSync <= txPinMeta;
    end
  end

  // wait gating: enables stay stored, only their effect is masked
  wire stopped  = ctrl.stopInWait && cpuWait;
  wire running  = !stopped;
  wire xmitLive = ctrl.xmitOn && running;
  wire rcvLive  = ctrl.rcvOn && running;

  function automatic ulw_route_type pick_route(input ulw_ctrl_type c);
    if (!c.wrapSelect) begin
      pick_route = ROUTE_PIN;
    end else if (!c.rxSourceSel) begin
      pick_route = ROUTE_WRAP;
    end else begin
      pick_route = ROUTE_SINGLE;
    end
  endfunction

  wire ulw_route_type route = pick_route(ctrl);

  // transmit line after its own polarity
  wire txLine = ctrl.txInvert ? !txData : txData;
  wire txIdle = xmitLive ? txLine : LINE_IDLE;

  logic rawRx;
  always_comb begin
    unique case (route)
      ROUTE_PIN:    rawRx = rxPinSync;
      // pin path cut off in both wrap routes
      ROUTE_WRAP:   rawRx = txIdle;
      ROUTE_SINGLE: rawRx = txPinSync;
      default:      rawRx = LINE_IDLE;
    endcase
  end

  // receive polarity applies on its own, regardless of transmit polarity
  wire rxLine    = ctrl.rxInvert ? !rawRx : rawRx;
  wire next_rx   = rcvLive ? rxLine : LINE_IDLE;
  // single-wire: drive the shared pin only while transmitting
  wire next_oe   = xmitLive;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      txPinOut <= LINE_IDLE;
      txPinOe  <= 1'h0;
      rxData   <= LINE_IDLE;
      status   <= STATUS_RESET;
    end else begin
      txPinOut <= txIdle;
      txPinOe  <= next_oe;
      rxData   <= next_rx;
      status   <= '{xmitActive: xmitLive, rcvActive: rcvLive,
                    lowPower: stopped};
    end
  end

  // serial clock enable; frozen, not reset, so it resumes in phase
  ulw_clk_div #(
    .DIV (BAUD_DIV)
  ) u_div (
    .clock  (clock),
    .resetn (resetn),
    .run    (running && (ctrl.xmitOn || ctrl.rcvOn)),
    .tick   (baudTick)
  );

endmodule

// ===== tb/ulw_properties.sv
/* checker: receive routing and wait gating seen at the top ports
   assumes bind to the block; config checked only once settled */
`timescale 1ns/1ps
module ulw_properties
  import ulw_pkg::*;
#(
  parameter int unsigned BAUD_DIV = BAUD_DIV_RESET
) (
  input wire logic           clock,
  input wire logic           resetn,
  input wire ulw_ctrl_type   ctrlOne,
  input wire logic           cpuWait,
  input wire logic           txData,
  input wire logic           rxPin,
  input wire logic           txPinIn,
  input wire logic           txPinOut,
  input wire logic           txPinOe,
  input wire logic           rxData,
  input wire logic           baudTick,
  input wire ulw_status_type status
);
  logic [1:0]   age;
  ulw_ctrl_type c1, c;
  // two-deep copy mirrors the config register plus output flop
  always_ff @(posedge clock) begin
    c1  <= ctrlOne;
    c   <= c1;
    age <= !resetn ? 2'h0 : age + 2'(age != 2'h3);
  end
  wire ok  = age == 2'h3 && c == c1 && c1 == ctrlOne;
  wire run = ok && c.rcvOn && c.xmitOn && !c.stopInWait;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence parked;
    ok && c.stopInWait && cpuWait;
  endsequence
  sequence wait_leave;
    ok && c.stopInWait && c.xmitOn && $fell(cpuWait);
  endsequence
  reset_idle_a: assert property (!$past(resetn) |-> txPinOut && !txPinOe
    && rxData && !baudTick && status == STATUS_RESET) else $error("reset");
  pin_blocked_a: assert property (run && c.wrapSelect && c.rxSourceSel
    |-> rxData == ($past(txPinIn, 3) ^ c.rxInvert)) else $error("wire");
  wrap_route_a: assert property (run && c.wrapSelect && !c.rxSourceSel
    |-> rxData == ($past(txData) ^ c.txInvert ^ c.rxInvert)) else $error("wrap");
  pin_route_a: assert property (run && !c.wrapSelect
    |-> rxData == ($past(rxPin, 3) ^ c.rxInvert)) else $error("pin");
  stop_idle_a: assert property (parked |=> !txPinOe && txPinOut && rxData
    && !baudTick && status.lowPower) else $error("stop");
  enables_kept_a: assert property (ok && c.stopInWait && c.xmitOn
    && c.rcvOn && !$past(cpuWait) |-> txPinOe && status.xmitActive
    && status.rcvActive) else $error("enables");
  wake_resume_a: assert property (wait_leave |=> txPinOe
    && !status.lowPower) else $error("wake");
  tick_period_a: assert property (baudTick && run |-> ##BAUD_DIV baudTick)
    else $error("tick");
endmodule
bind uart_loopback_wait_ctl ulw_properties #(.BAUD_DIV(BAUD_DIV))
  ulw_properties_i (.clock(clock), .resetn(resetn), .ctrlOne(ctrlOne),
  .cpuWait(cpuWait), .txData(txData), .rxPin(rxPin), .txPinIn(txPinIn),
  .txPinOut(txPinOut), .txPinOe(txPinOe), .rxData(rxData),
  .baudTick(baudTick), .status(status));

// ===== tb/ulw_remote.sv
/* remote transceiver on the two pins
   assumes a pull-up on the transmit pin when it is released */
`timescale 1ns/1ps
module ulw_remote (
  input  wire logic clock,
  input  wire logic txPinOut,
  input  wire logic txPinOe,
  output logic      rxPin,
  output logic      txPinIn
);
  // fresh random level every cycle so a stale value mismatches about half the time
  initial begin
    rxPin = 1'h1;
    forever @(negedge clock) rxPin <= 1'($urandom);
  end
  assign txPinIn = txPinOe ? txPinOut : 1'h1;
endmodule

// ===== tb/uart_loopback_wait_ctl_test.sv
/* bench: all routing modes, then wait gating, against a model
   assumes the remote model on the pins and the bound checker */
`timescale 1ns/1ps
module uart_loopback_wait_ctl_test;
  import ulw_pkg::*;
  logic           clock = 0, resetn = 0, cpuWait = 0, txData = 0;
  ulw_ctrl_type   ctrlOne = CTRL_RESET;
  logic           rxPin, txPinIn, txPinOut, txPinOe, rxData, baudTick;
  ulw_status_type status;
  logic [2:0]     qp, qt;
  int             n_errors = 0, num_checks = 0, n;
  uart_loopback_wait_ctl #(.BAUD_DIV(4)) uart_loopback_wait_ctl_i (
    .clock(clock), .resetn(resetn), .ctrlOne(ctrlOne),
    .cpuWait(cpuWait), .txData(txData), .rxPin(rxPin), .txPinIn(txPinIn),
    .txPinOut(txPinOut), .txPinOe(txPinOe), .rxData(rxData),
    .baudTick(baudTick), .status(status));
  ulw_remote ulw_remote_i (.clock(clock), .txPinOut(txPinOut),
    .txPinOe(txPinOe), .rxPin(rxPin), .txPinIn(txPinIn));
  initial forever #2.5 clock = ~clock;
  always @(posedge clock) begin
    qp <= {qp[1:0], rxPin};
    qt <= {qt[1:0], txPinIn};
  end
  function automatic logic model(ulw_ctrl_type k);
    logic r;
    r = !k.wrapSelect ? qp[2] : (k.rxSourceSel ? qt[2] : txData ^ k.txInvert);
    return r ^ k.rxInvert;
  endfunction
  task automatic check(logic [6:0] got, logic [6:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #20us;
    n_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h1B85));
    repeat (2) @(negedge clock);
    resetn = 1;
    for (int i = 0; i < 16; i++) begin
      ctrlOne = {4'(i), 3'h3};
      repeat (4) @(negedge clock);
      repeat (24) begin
        txData = 1'($urandom);
        cpuWait = 1'($urandom);
        @(posedge clock); #1;
        check(7'(rxData), 7'(model(ctrlOne)));
        check(7'({txPinOe, txPinOut}), 7'({1'h1, txData ^ ctrlOne.txInvert}));
        @(negedge clock);
      end
    end
    cpuWait = 0;
    ctrlOne = 7'h07;
    repeat (4) @(negedge clock);
    check({txPinOe, status}, 7'h0E);
    cpuWait = 1;
    repeat (12) begin
      @(posedge clock); #1;
      check({txPinOe, txPinOut, rxData, baudTick, status}, 7'h31);
    end
    @(negedge clock) cpuWait = 0;
    @(posedge clock); #1;
    check({txPinOe, status}, 7'h0E);
    n = 0;
    repeat (8) begin
      @(posedge clock); #1;
      n += baudTick;
    end
    check(7'(n), 7'h02);
    end_sim();
  end
endmodule
